// >>> design/ctim_pkg.sv
// Purpose: shared constants and types for the three-channel compact 10-bit timer
// Assumes: byte-wide timer registers, one per aligned 32-bit AHB-Lite word
// Notes: each timer channel occupies a 32-byte window; channel index is haddr[6:5]
package ctim_pkg;

   // ==========================================================
   // address map
   localparam int NUM_TIMERS = 3;
   localparam int CH_LSB = 5;
   localparam logic [4:0] OFF_CTRL0 = 5'h00;
   localparam logic [4:0] OFF_CTRL1 = 5'h04;
   localparam logic [4:0] OFF_CNT_LO = 5'h08;
   localparam logic [4:0] OFF_CNT_HI = 5'h0c;
   localparam logic [4:0] OFF_CMPA_LO = 5'h10;
   localparam logic [4:0] OFF_CMPA_HI = 5'h14;
   localparam logic [4:0] OFF_FLAGS = 5'h18;

   // ==========================================================
   // reset values
   localparam logic [7:0] CTRL0_RST = 8'h00;
   localparam logic [7:0] CTRL1_RST = 8'h00;
   localparam logic [9:0] CNT_RST = 10'h000;
   localparam logic [9:0] CMPA_RST = 10'h000;
   localparam logic [7:0] BUF_RST = 8'h00;

   // ==========================================================
   // field codes
   localparam logic [2:0] CLK_SYS_DIV4 = 3'h0;
   localparam logic [2:0] CLK_SYS = 3'h1;
   localparam logic [2:0] CLK_H_DIV16 = 3'h2;
   localparam logic [2:0] CLK_H_DIV64 = 3'h3;
   localparam logic [2:0] CLK_SUB_A = 3'h4;
   localparam logic [2:0] CLK_SUB_B = 3'h5;
   localparam logic [1:0] MODE_CMP = 2'h0;
   localparam logic [1:0] MODE_PWM = 2'h2;
   localparam logic [1:0] MODE_TMR = 2'h3;
   localparam logic [1:0] ACT_NONE = 2'h0;
   localparam logic [1:0] ACT_LOW = 2'h1;
   localparam logic [1:0] ACT_HIGH = 2'h2;
   localparam logic [1:0] ACT_TOGGLE = 2'h3;
   localparam logic [1:0] PWM_INACTIVE = 2'h0;
   localparam logic [1:0] PWM_ACTIVE = 2'h1;
   localparam logic [1:0] PWM_RUN = 2'h2;
   localparam int PERIOD_LSB = 7;

   // ==========================================================
   // prescaler terminal counts
   localparam logic [1:0] SYS_DIV4_LAST = 2'h3;
   localparam logic [5:0] H_DIV16_LAST = 6'h0f;
   localparam logic [5:0] H_DIV64_LAST = 6'h3f;

   // ==========================================================
   // types
   typedef struct packed {
      logic pause;
      logic [2:0] clk_sel;
      logic on;
      logic [2:0] period;
   } ctim_ctrl0_t;

   typedef struct packed {
      logic [1:0] mode;
      logic [1:0] act;
      logic init_level;
      logic invert;
      logic role_swap;
      logic clr_src;
   } ctim_ctrl1_t;

   typedef struct packed {
      logic sys_div4;
      logic h_div16;
      logic h_div64;
      logic sub;
   } ctim_ticks_t;

   typedef struct packed {
      logic wr;
      logic rd;
      logic [4:0] off;
      logic [7:0] wdata;
   } ctim_acc_t;

   typedef struct packed {
      ctim_ctrl0_t ctrl0;
      ctim_ctrl1_t ctrl1;
      logic [9:0] cnt;
      logic [9:0] cmpa;
      logic [7:0] buff;
      logic flag_a;
      logic flag_p;
      logic level;
      logic pin;
   } ctim_core_t;

   typedef enum logic [1:0] {PH_IDLE, PH_WRITE, PH_RDWAIT, PH_RDDONE} ctim_phase_t;

   typedef struct packed {
      ctim_phase_t phase;
      logic [7:0] addr;
      logic [31:0] hrdata;
      logic [1:0] div4;
      logic [5:0] hdiv;
   } ctim_top_t;

endpackage

// >>> design/ctim_timer.sv
// Purpose: three compact 10-bit timers behind an AHB-Lite slave
// Assumes: high_tick and sub_tick are one-cycle pulses synchronous to hclk
// Notes: writes take no wait state, reads take one
// Overview of operation
// - three identical independent timer channels
// - 10-bit up-counter advances on selected tick
// - clock select picks sys/4, sys, h/16, h/64, sub
// - pause holds the count, resume continues
// - on rising clears and starts; falling holds
// - on rising forces pin to initial level, except in timer mode
// - software cannot load the counter directly
// - comparator P checks counter bits 9..7
// - period code zero wraps by overflow
// - comparator A checks all ten bits
// - separate A and P match requests
// - clear source zero clears on P or overflow, outside pwm mode (pwm uses role swap)
// - inverted pin always mirrors true pin
// - compare mode drives pin high, low, toggle
// - low byte buffered until high byte write
// - high byte read latches low byte
// - counter read-only, compare A read-write
// - mode select: compare, pwm, timer
// - clear source one clears on A, no P, outside pwm mode (pwm uses role swap)
// - pin action code on A match
// - pwm active level and pin inversion
`timescale 1ns/1ps

// ==========================================================
// one timer channel
module ctim_core (
   input wire logic hclk,
   input wire logic hresetn,
   input wire ctim_pkg::ctim_ticks_t ticks,
   input wire ctim_pkg::ctim_acc_t acc,
   input wire logic sel,
   output logic [7:0] rdata,
   output logic match_a_flag,
   output logic match_p_flag,
   output logic timer_out,
   output logic timer_out_n
);
   ctim_pkg::ctim_core_t q;
   ctim_pkg::ctim_core_t d;
   logic tick;
   logic start;
   logic [10:0] nxt;
   logic a_hit;
   logic p_hit;
   logic pwm;
   logic clr_on_a;
   logic clear;
   logic duty_on;
   logic [9:0] p_full;

   // ==========================================================
   // register read mux, no side effect here
   always_comb begin
      case (acc.off)
         ctim_pkg::OFF_CTRL0: rdata = q.ctrl0;
         ctim_pkg::OFF_CTRL1: rdata = q.ctrl1;
         ctim_pkg::OFF_CNT_LO: rdata = q.buff;
         ctim_pkg::OFF_CNT_HI: rdata = {6'h00, q.cnt[9:8]};
         ctim_pkg::OFF_CMPA_LO: rdata = q.buff;
         ctim_pkg::OFF_CMPA_HI: rdata = {6'h00, q.cmpa[9:8]};
         ctim_pkg::OFF_FLAGS: rdata = {6'h00, q.flag_p, q.flag_a};
         default: rdata = 8'h00;
      endcase
   end

   // ==========================================================
   // next state
   always_comb begin
      d = q;
      start = 1'b0;
      case (q.ctrl0.clk_sel)
         ctim_pkg::CLK_SYS_DIV4: tick = ticks.sys_div4;
         ctim_pkg::CLK_SYS: tick = 1'b1;
         ctim_pkg::CLK_H_DIV16: tick = ticks.h_div16;
         ctim_pkg::CLK_H_DIV64: tick = ticks.h_div64;
         ctim_pkg::CLK_SUB_A: tick = ticks.sub;
         ctim_pkg::CLK_SUB_B: tick = ticks.sub;
         default: tick = 1'b0;
      endcase
      nxt = {1'b0, q.cnt} + 11'h001;
      p_full = {q.ctrl0.period, 7'h00};
      a_hit = (q.cmpa != 10'h000) && (nxt == {1'b0, q.cmpa});
      if (q.ctrl0.period != 3'h0) begin
         p_hit = (nxt == {1'b0, p_full});
      end else begin
         p_hit = nxt[10];
      end
      pwm = (q.ctrl1.mode == ctim_pkg::MODE_PWM);
      clr_on_a = pwm ? q.ctrl1.role_swap : q.ctrl1.clr_src;
      clear = clr_on_a ? a_hit : p_hit;

      // bus writes; the counter itself has no write path
      if (acc.wr && sel) begin
         case (acc.off)
            ctim_pkg::OFF_CTRL0: begin
               d.ctrl0 = ctim_pkg::ctim_ctrl0_t'(acc.wdata);
               start = acc.wdata[3] && !q.ctrl0.on;
            end
            ctim_pkg::OFF_CTRL1: begin
               d.ctrl1 = ctim_pkg::ctim_ctrl1_t'(acc.wdata);
            end
            ctim_pkg::OFF_CMPA_LO: begin
               d.buff = acc.wdata;
            end
            ctim_pkg::OFF_CMPA_HI: begin
               d.cmpa = {acc.wdata[1:0], q.buff};
            end
            ctim_pkg::OFF_FLAGS: begin
               // write one to clear; a same-cycle match below wins
               if (acc.wdata[0]) begin
                  d.flag_a = 1'b0;
               end
               if (acc.wdata[1]) begin
                  d.flag_p = 1'b0;
               end
            end
            default: begin
            end
         endcase
      end

      // high byte reads latch the low byte into the shared buffer
      if (acc.rd && sel) begin
         case (acc.off)
            ctim_pkg::OFF_CNT_HI: d.buff = q.cnt[7:0];
            ctim_pkg::OFF_CMPA_HI: d.buff = q.cmpa[7:0];
            default: begin
            end
         endcase
      end

      if (start) begin
         d.cnt = ctim_pkg::CNT_RST;
         if (q.ctrl1.mode != ctim_pkg::MODE_TMR) begin
            d.level = q.ctrl1.init_level;
         end
      end else if (q.ctrl0.on && !q.ctrl0.pause && tick) begin
         d.cnt = clear ? 10'h000 : nxt[9:0];
         if (a_hit) begin
            d.flag_a = 1'b1;
         end
         if (p_hit && (pwm || !q.ctrl1.clr_src)) begin
            d.flag_p = 1'b1;
         end
         if (a_hit && q.ctrl1.mode == ctim_pkg::MODE_CMP) begin
            case (q.ctrl1.act)
               ctim_pkg::ACT_LOW: d.level = 1'b0;
               ctim_pkg::ACT_HIGH: d.level = 1'b1;
               ctim_pkg::ACT_TOGGLE: d.level = !q.level;
               default: d.level = q.level;
            endcase
         end
      end

      // edge-aligned pwm: duty register sets how long the level is active
      duty_on = q.ctrl1.role_swap ? (q.cnt < p_full) : (q.cnt < q.cmpa);
      if (pwm && q.ctrl0.on && !start) begin
         case (q.ctrl1.act)
            ctim_pkg::PWM_INACTIVE: d.level = !q.ctrl1.init_level;
            ctim_pkg::PWM_ACTIVE: d.level = q.ctrl1.init_level;
            ctim_pkg::PWM_RUN: d.level = duty_on ? q.ctrl1.init_level : !q.ctrl1.init_level;
            default: d.level = !q.ctrl1.init_level;
         endcase
      end

      // inversion ignored in timer mode, where the pin has no meaning
      d.pin = d.level ^ (q.ctrl1.invert && q.ctrl1.mode != ctim_pkg::MODE_TMR);
   end

   // ==========================================================
   // state register
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q.ctrl0 <= ctim_pkg::ctim_ctrl0_t'(ctim_pkg::CTRL0_RST);
         q.ctrl1 <= ctim_pkg::ctim_ctrl1_t'(ctim_pkg::CTRL1_RST);
         q.cnt <= ctim_pkg::CNT_RST;
         q.cmpa <= ctim_pkg::CMPA_RST;
         q.buff <= ctim_pkg::BUF_RST;
         q.flag_a <= 1'b0;
         q.flag_p <= 1'b0;
         q.level <= 1'b0;
         q.pin <= 1'b0;
      end else begin
         q <= d;
      end
   end

   assign match_a_flag = q.flag_a;
   assign match_p_flag = q.flag_p;
   assign timer_out = q.pin;
   assign timer_out_n = !q.pin;

endmodule // ctim_core

// ==========================================================
// bus slave, shared prescalers and the three channels
module ctim_timer (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [2:0] hsize,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   output logic hreadyout,
   output logic hresp,
   output logic [31:0] hrdata,
   input wire logic high_tick,
   input wire logic sub_tick,
   output logic [2:0] timer_out,
   output logic [2:0] timer_out_n,
   output logic [2:0] match_a_flag,
   output logic [2:0] match_p_flag
);
   ctim_pkg::ctim_top_t q;
   ctim_pkg::ctim_top_t d;
   ctim_pkg::ctim_ticks_t ticks;
   ctim_pkg::ctim_acc_t acc;
   logic [7:0] rdata [ctim_pkg::NUM_TIMERS];
   logic [1:0] ch;
   logic [7:0] rsel;
   logic take;

   // ==========================================================
   // prescaled ticks, shared by all channels
   always_comb begin
      ticks.sys_div4 = (q.div4 == ctim_pkg::SYS_DIV4_LAST);
      ticks.h_div16 = high_tick && (q.hdiv[3:0] == ctim_pkg::H_DIV16_LAST[3:0]);
      ticks.h_div64 = high_tick && (q.hdiv == ctim_pkg::H_DIV64_LAST);
      ticks.sub = sub_tick;
   end

   // ==========================================================
   // access decode; reads wait one cycle so a preceding write is visible
   always_comb begin
      ch = q.addr[6:5];
      acc.wr = (q.phase == ctim_pkg::PH_WRITE);
      acc.rd = (q.phase == ctim_pkg::PH_RDWAIT);
      acc.off = q.addr[4:0];
      acc.wdata = hwdata[7:0];
      rsel = 8'h00;
      for (int i = 0; i < ctim_pkg::NUM_TIMERS; i++) begin
         if (ch == i[1:0]) begin
            rsel = rdata[i];
         end
      end
   end

   always_comb begin
      d = q;
      take = hsel && htrans[1] && hready;
      d.div4 = q.div4 + 2'h1;
      d.hdiv = high_tick ? q.hdiv + 6'h01 : q.hdiv;
      case (q.phase)
         ctim_pkg::PH_RDWAIT: begin
            d.hrdata = {24'h000000, rsel};
            d.phase = ctim_pkg::PH_RDDONE;
         end
         default: begin
            d.phase = ctim_pkg::PH_IDLE;
         end
      endcase
      if (take && q.phase != ctim_pkg::PH_RDWAIT) begin
         d.addr = haddr[7:0];
         d.phase = hwrite ? ctim_pkg::PH_WRITE : ctim_pkg::PH_RDWAIT;
      end
   end

   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         q.phase <= ctim_pkg::PH_IDLE;
         q.addr <= 8'h00;
         q.hrdata <= 32'h00000000;
         q.div4 <= 2'h0;
         q.hdiv <= 6'h00;
      end else begin
         q <= d;
      end
   end

   assign hreadyout = (q.phase != ctim_pkg::PH_RDWAIT);
   assign hresp = 1'b0;
   assign hrdata = q.hrdata;

   // ==========================================================
   // channels
   for (genvar g = 0; g < ctim_pkg::NUM_TIMERS; g++) begin : g_ch
      ctim_core u_core (
         .hclk(hclk),
         .hresetn(hresetn),
         .ticks(ticks),
         .acc(acc),
         .sel(ch == 2'(g)),
         .rdata(rdata[g]),
         .match_a_flag(match_a_flag[g]),
         .match_p_flag(match_p_flag[g]),
         .timer_out(timer_out[g]),
         .timer_out_n(timer_out_n[g])
      );
   end

endmodule // ctim_timer

// >>> tb/ctim_tick_src.sv
// Purpose: high and sub clock tick source for the timer
// Assumes: ticks are one-cycle pulses on hclk
// Notes: fixed spacing keeps tick-based periods exact
`timescale 1ns/1ps
// ==========================================================
// tick source
module ctim_tick_src #(
   parameter int HDIV = 2,
   parameter int SDIV = 3
) (
   input wire logic hclk,
   input wire logic hresetn,
   output logic high_tick,
   output logic sub_tick
);
   int hc;
   int sc;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) begin
         hc <= 0;
         sc <= 0;
      end else begin
         hc <= (hc == HDIV - 1) ? 0 : hc + 1;
         sc <= (sc == SDIV - 1) ? 0 : sc + 1;
      end
   end
   assign high_tick = (hc == 0);
   assign sub_tick = (sc == 0);
endmodule // ctim_tick_src

// >>> tb/ctim_checker.sv
// Purpose: port assertions for ctim_timer
// Assumes: one hclk domain
// Notes: flags may only fall after a bus write
`timescale 1ns/1ps
// ==========================================================
// checker
module ctim_checker (
   input wire logic hclk,
   input wire logic hresetn,
   input wire logic hsel,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [2:0] timer_out,
   input wire logic [2:0] timer_out_n,
   input wire logic [2:0] match_a_flag,
   input wire logic [2:0] match_p_flag
);
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   logic go;
   logic wph_q;
   assign go = hsel & htrans[1] & hready;
   always_ff @(posedge hclk or negedge hresetn) begin
      if (!hresetn) wph_q <= 1'b0;
      else wph_q <= go & hwrite;
   end
   a_pin_inverse: assert property (timer_out_n == ~timer_out) else $error("inverted pin wrong");
   a_resp_okay: assert property (hresp == 1'b0) else $error("response not okay");
   a_write_nowait: assert property (go && hwrite |=> hreadyout) else $error("write waited");
   a_read_wait: assert property (go && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read wait wrong");
   a_wait_cause: assert property ($fell(hreadyout) |-> $past(go && !hwrite))
      else $error("wait without read");
   a_rdata_hold: assert property (!$stable(hrdata) |-> $rose(hreadyout))
      else $error("read data moved");
   a_rdata_upper: assert property (hrdata[31:8] == 24'h0) else $error("upper read bits set");
   a_flag_fall: assert property (|($past(match_a_flag) & ~match_a_flag) || |($past(match_p_flag) & ~match_p_flag)
      |-> $past(wph_q)) else $error("flag fell without write");
endmodule // ctim_checker

bind ctim_timer ctim_checker i_chk (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .htrans(htrans),
   .hwrite(hwrite), .hready(hready), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
   .timer_out(timer_out), .timer_out_n(timer_out_n), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));

// >>> tb/ctim_timer_tb.sv
// Purpose: self-checking bench for ctim_timer
// Assumes: byte registers, one per aligned word
// Notes: periods measured between flag sets
`timescale 1ns/1ps
// ==========================================================
// bench top
module ctim_timer_tb;
   localparam int HDIV = 2;
   localparam int SDIV = 3;
   logic hclk;
   logic hresetn;
   logic hsel;
   logic [31:0] haddr;
   logic [1:0] htrans;
   logic hwrite;
   logic [31:0] hwdata;
   logic hreadyout;
   logic [31:0] hrdata;
   logic high_tick;
   logic sub_tick;
   logic [2:0] timer_out;
   logic [2:0] match_a_flag;
   logic [2:0] match_p_flag;
   logic [31:0] rd;
   logic [31:0] c1;
   logic [31:0] c2;
   logic [7:0] lo;
   logic [1:0] hi;
   logic b;
   logic inv;
   int num_errors;
   int compares;
   int cycles;
   int t0;
   int t1;
   int cs;
   int pc;
   int exp;
   int cmpa_m [3];
   ctim_timer i_dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
      .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout),
      .hresp(), .hrdata(hrdata), .high_tick(high_tick), .sub_tick(sub_tick), .timer_out(timer_out),
      .timer_out_n(), .match_a_flag(match_a_flag), .match_p_flag(match_p_flag));
   ctim_tick_src #(.HDIV(HDIV), .SDIV(SDIV)) i_src (.hclk(hclk), .hresetn(hresetn),
      .high_tick(high_tick), .sub_tick(sub_tick));
   // ==========================================================
   // tasks
   task automatic report_and_stop();
      $display("errors %0d compares %0d", num_errors, compares);
      if (num_errors == 0 && compares > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input logic [31:0] got, input logic [31:0] want);
      compares++;
      if (got !== want) begin
         num_errors++;
         $display("FAIL t=%0t got %h want %h", $time, got, want);
      end
   endtask
   // one single transfer; waits on hready, never a fixed count
   task automatic xfer(input bit w, input int ch, input logic [4:0] off, input logic [7:0] d);
      haddr <= {25'h0, 2'(ch), off};
      hwrite <= w;
      htrans <= 2'h2;
      hsel <= 1'b1;
      do @(posedge hclk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hwdata <= {24'h0, d};
      do @(posedge hclk); while (hreadyout !== 1'b1);
      rd = hrdata;
   endtask
   task automatic rcnt(input int ch, output logic [31:0] c);
      xfer(0, ch, 5'h0c, 8'h00);
      c = rd << 8;
      xfer(0, ch, 5'h08, 8'h00);
      c = c | rd;
   endtask
   task automatic wait_flag(input int ch, input bit p, output int t);
      do @(posedge hclk); while ((p ? match_p_flag[ch] : match_a_flag[ch]) !== 1'b1);
      t = cycles;
   endtask
   // ==========================================================
   // clock, timeout, sequence
   initial begin
      hclk = 1'b0;
      forever #12.5 hclk = ~hclk;
   end
   always @(posedge hclk) begin
      cycles <= cycles + 1;
      if (cycles == 95000) begin
         num_errors++;
         report_and_stop();
      end
   end
   initial begin
      hresetn = 1'b0;
      hsel = 1'b0;
      haddr = 32'h0;
      htrans = 2'h0;
      hwrite = 1'b0;
      hwdata = 32'h0;
      t0 = $urandom(32'hb1e2);
      repeat (6) @(posedge hclk);
      hresetn <= 1'b1;
      @(posedge hclk);
      for (int ch = 0; ch < 4; ch++) begin
         for (int r = 0; r < 6; r++) begin
            xfer(0, ch, 5'(4 * r), 8'h00);
            chk(rd, 32'h0);
         end
      end
      for (int ch = 0; ch < 3; ch++) begin
         lo = 8'($urandom);
         xfer(1, ch, 5'h04, lo);
         xfer(0, ch, 5'h04, 8'h00);
         chk(rd, {24'h0, lo});
         hi = 2'($urandom);
         lo = 8'($urandom);
         xfer(1, ch, 5'h10, lo);
         xfer(0, ch, 5'h14, 8'h00);
         chk(rd, 32'(cmpa_m[ch] >> 8));
         // high read above reloaded the shared buffer, so the low byte goes in again
         xfer(1, ch, 5'h10, lo);
         xfer(1, ch, 5'h14, {6'h0, hi});
         cmpa_m[ch] = {hi, lo};
         xfer(0, ch, 5'h14, 8'h00);
         chk(rd, {30'h0, hi});
         xfer(0, ch, 5'h10, 8'h00);
         chk(rd, {24'h0, lo});
         xfer(1, ch, 5'h0c, lo);
         xfer(1, ch, 5'h08, lo);
         rcnt(ch, c1);
         chk(c1, 32'h0);
         xfer(1, ch, 5'h04, 8'h00);
      end
      // every period code on the system clock, then each clock source
      for (int k = 0; k < 13; k++) begin
         cs = (k < 8) ? 1 : (k == 8) ? 0 : k - 7;
         pc = (k < 8) ? k : 1;
         exp = ((pc == 0) ? 1024 : pc * 128) * ((cs == 0) ? 4 : (cs == 1) ? 1 : (cs == 2) ? 16 * HDIV :
            (cs == 3) ? 64 * HDIV : SDIV);
         xfer(1, 1, 5'h00, 8'h00);
         xfer(1, 1, 5'h04, k[0] ? 8'hc0 : 8'h00);
         xfer(1, 1, 5'h00, {1'b0, 3'(cs), 1'b1, 3'(pc)});
         xfer(1, 1, 5'h18, 8'h03);
         wait_flag(1, 1'b1, t0);
         xfer(1, 1, 5'h18, 8'h03);
         wait_flag(1, 1'b1, t1);
         chk(32'(t1 - t0), 32'(exp));
      end
      chk(32'({match_p_flag[2], match_p_flag[0]}), 32'h0);
      // every pin action with comparator A clearing
      for (int act = 0; act < 4; act++) begin
         b = 1'($urandom);
         inv = 1'($urandom);
         exp = 130 + ($urandom % 300);
         xfer(1, 1, 5'h00, 8'h00);
         xfer(1, 1, 5'h10, 8'(exp));
         xfer(1, 1, 5'h14, 8'(exp >> 8));
         xfer(1, 1, 5'h04, {2'h0, 2'(act), b, inv, 2'h1});
         xfer(1, 1, 5'h00, 8'h19);
         repeat (3) @(posedge hclk);
         chk(32'(timer_out[1]), 32'(b ^ inv));
         xfer(1, 1, 5'h18, 8'h03);
         wait_flag(1, 1'b0, t0);
         repeat (2) @(posedge hclk);
         c1 = {31'h0, (act == 0) ? b : (act == 1) ? 1'b0 : (act == 2) ? 1'b1 : ~b};
         chk(32'(timer_out[1] ^ inv), c1);
         xfer(1, 1, 5'h18, 8'h03);
         wait_flag(1, 1'b0, t1);
         chk(32'(t1 - t0), 32'(exp));
         chk(32'(match_p_flag[1]), 32'h0);
      end
      // pwm on channel 0: fixed states, then active cycles over one whole period
      for (int act = 0; act < 3; act++) begin
         b = 1'($urandom);
         inv = 1'($urandom);
         exp = 1 + ($urandom % 126);
         xfer(1, 0, 5'h00, 8'h00);
         xfer(1, 0, 5'h10, 8'(exp));
         xfer(1, 0, 5'h14, 8'h00);
         xfer(1, 0, 5'h04, {2'h2, 2'(act), b, inv, 2'h0});
         xfer(1, 0, 5'h00, 8'h19);
         repeat (140) @(posedge hclk);
         pc = 0;
         for (int i = 0; i < 128; i++) begin
            @(posedge hclk);
            pc += ((timer_out[0] ^ inv) == b);
         end
         chk(32'(pc), 32'((act == 0) ? 0 : (act == 1) ? 128 : exp));
      end
      // pause holds, off holds, on clears
      xfer(1, 2, 5'h00, 8'h18);
      repeat (20) @(posedge hclk);
      xfer(1, 2, 5'h00, 8'h98);
      rcnt(2, c1);
      repeat (40) @(posedge hclk);
      rcnt(2, c2);
      chk(c2, c1);
      xfer(1, 2, 5'h00, 8'h18);
      repeat (20) @(posedge hclk);
      xfer(1, 2, 5'h00, 8'h10);
      rcnt(2, c2);
      chk(32'((c2 > c1 + 19) && (c2 < c1 + 40)), 32'h1);
      repeat (40) @(posedge hclk);
      rcnt(2, c1);
      chk(c1, c2);
      xfer(1, 2, 5'h00, 8'h18);
      rcnt(2, c1);
      chk(32'(c1 < 16), 32'h1);
      report_and_stop();
   end
endmodule // ctim_timer_tb
